// File: hdl/sdram_mode_register_bank.sv
module sdram_mode_register_bank
    import mode_reg_pkg::*;
#(
    parameter int AUTO_INIT_CYCLES_P = AUTO_INIT_CYCLES,
    parameter logic [7:0] MAKER_CODE_P = 8'h5A,     // Arbitrary value
    parameter logic [7:0] REVISION_ONE_P = 8'h01,   // Arbitrary value
    parameter logic [7:0] REVISION_TWO_P = 8'h02,   // Arbitrary value
    parameter logic [7:0] WIDTH_DENSITY_P = 8'h00,
    parameter logic [7:0] REFRESH_RATE_P = 8'h03
)
(
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    // Controller side
    input wire logic CKE_IN,
    input wire mode_cmd_type CMD_IN,
    // Read data path
    output read_out_type READ_OUT,
    // Status
    output logic INIT_BUSY_OUT,
    output logic CAL_BUSY_OUT,
    output logic [7:0] BURST_LENGTH_CFG_OUT
);

    // ------------------------------------------------------------
    // Clock enable synchroniser
    // ------------------------------------------------------------
    logic cke_s1_q, cke_s2_q, cke_s3_q, cke_q;

    // Pin input: change accepted when stages two and three agree
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            cke_s1_q <= 1'b0;
            cke_s2_q <= 1'b0;
            cke_s3_q <= 1'b0;
            cke_q <= 1'b0;
        end
        else
        begin
            cke_s1_q <= CKE_IN;
            cke_s2_q <= cke_s1_q;
            cke_s3_q <= cke_s2_q;
            if (cke_s2_q == cke_s3_q)
            begin
                cke_q <= cke_s3_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Address classification
    // ------------------------------------------------------------
    function automatic access_class_type classify(input logic [7:0] addr);
        access_class_type cls;
        cls = ACCESS_RESERVED;
        case (addr)
            ADDR_DEVICE_INFO, ADDR_REFRESH_RATE_STATUS, ADDR_MAKER_CODE,
            ADDR_REVISION_CODE_ONE, ADDR_REVISION_CODE_TWO, ADDR_WIDTH_DENSITY_TYPE,
            ADDR_DQ_PATTERN_A, ADDR_DQ_PATTERN_B:
                cls = ACCESS_READ_ONLY;
            ADDR_DEVICE_FEATURE_ONE, ADDR_DEVICE_FEATURE_TWO, ADDR_IO_CONFIG_ONE,
            ADDR_VENDOR_TEST_MODE, ADDR_IMPEDANCE_CALIBRATION,
            ADDR_PARTIAL_REFRESH_BANK_MASK, ADDR_PARTIAL_REFRESH_SEGMENT_MASK,
            ADDR_DEVICE_RESET_TRIGGER:
                cls = ACCESS_WRITE_ONLY;
            default:
                cls = ACCESS_RESERVED;
        endcase
        return cls;
    endfunction

    // Commands only count while clock enable is high
    logic init_busy_q;
    logic cmd_write, cmd_read, reset_cmd, cal_cmd;
    assign cmd_write = CMD_IN.write_valid && cke_q
        && (classify(CMD_IN.address) == ACCESS_WRITE_ONLY);
    assign cmd_read = CMD_IN.read_valid && cke_q;
    assign reset_cmd = cmd_write && (CMD_IN.address == ADDR_DEVICE_RESET_TRIGGER);
    assign cal_cmd = cmd_write && (CMD_IN.address == ADDR_IMPEDANCE_CALIBRATION) && !init_busy_q;

    // ------------------------------------------------------------
    // Auto-initialisation sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {INIT_RUN, INIT_IDLE, CAL_RUN} init_state_type;
    init_state_type state_q;
    logic [15:0] timer_q;
    logic cal_busy_q;

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            state_q <= INIT_RUN;
            timer_q <= 16'h0000;
        end
        else if (reset_cmd)
        begin
            state_q <= INIT_RUN;
            timer_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                INIT_RUN:
                begin
                    if (timer_q >= 16'(AUTO_INIT_CYCLES_P - 1))
                    begin
                        state_q <= INIT_IDLE;
                        timer_q <= 16'h0000;
                    end
                    else
                    begin
                        timer_q <= timer_q + 16'h0001;
                    end
                end
                INIT_IDLE:
                begin
                    timer_q <= 16'h0000;
                    if (cal_cmd)
                    begin
                        state_q <= CAL_RUN;
                    end
                end
                CAL_RUN:
                begin
                    if (timer_q >= 16'(CALIBRATION_CYCLES - 1))
                    begin
                        state_q <= INIT_IDLE;
                        timer_q <= 16'h0000;
                    end
                    else
                    begin
                        timer_q <= timer_q + 16'h0001;
                    end
                end
                default:
                begin
                    state_q <= INIT_RUN;
                    timer_q <= 16'h0000;
                end
            endcase
        end
    end

    assign init_busy_q = (state_q == INIT_RUN);
    assign cal_busy_q = (state_q == CAL_RUN);

    // ------------------------------------------------------------
    // Write-only register storage
    // ------------------------------------------------------------
    localparam int NUM_WO = 8;
    localparam logic [7:0] WO_ADDR [NUM_WO] = '{ADDR_DEVICE_FEATURE_ONE, ADDR_DEVICE_FEATURE_TWO,
        ADDR_IO_CONFIG_ONE, ADDR_VENDOR_TEST_MODE, ADDR_IMPEDANCE_CALIBRATION,
        ADDR_PARTIAL_REFRESH_BANK_MASK, ADDR_PARTIAL_REFRESH_SEGMENT_MASK, ADDR_DEVICE_RESET_TRIGGER};
    logic [7:0] wo_q [NUM_WO];

    // Device reset clears every stored parameter, including its own trigger
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WO; gi++)
        begin : g_wo
            always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
            begin
                if (!RESET_N_IN)
                begin
                    wo_q[gi] <= WRITE_ONLY_RESET_VALUE;
                end
                else if (reset_cmd)
                begin
                    wo_q[gi] <= WRITE_ONLY_RESET_VALUE;
                end
                else if (cmd_write && (CMD_IN.address == WO_ADDR[gi]))
                begin
                    wo_q[gi] <= CMD_IN.operand;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] read_value;

    always_comb
    begin
        read_value = READ_FILL_VALUE;
        case (CMD_IN.address)
            ADDR_DEVICE_INFO:
                read_value = {7'h00, init_busy_q} & DEVICE_INFO_USED_MASK;
            ADDR_REFRESH_RATE_STATUS:
                read_value = REFRESH_RATE_P & REFRESH_RATE_USED_MASK;
            ADDR_MAKER_CODE:
                read_value = MAKER_CODE_P;
            ADDR_REVISION_CODE_ONE:
                read_value = REVISION_ONE_P;
            ADDR_REVISION_CODE_TWO:
                read_value = REVISION_TWO_P;
            ADDR_WIDTH_DENSITY_TYPE:
                read_value = WIDTH_DENSITY_P;
            ADDR_DQ_PATTERN_A:
                read_value = DQ_PATTERN_A_VALUE;
            ADDR_DQ_PATTERN_B:
                read_value = DQ_PATTERN_B_VALUE;
            default:
                read_value = READ_FILL_VALUE;
        endcase
    end

    // Burst of fixed length; strobe toggles whatever the address class
    logic [1:0] burst_q;
    logic [7:0] read_data_q;
    logic strobe_q;

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            burst_q <= 2'h0;
            read_data_q <= 8'h00;
            strobe_q <= 1'b0;
        end
        else if (!cke_q)
        begin
            burst_q <= 2'h0;
            strobe_q <= 1'b0;
        end
        else if (cmd_read)
        begin
            burst_q <= 2'(READ_BURST_CYCLES);
            read_data_q <= read_value;
            strobe_q <= 1'b1;
        end
        else if (burst_q != 2'h0)
        begin
            burst_q <= burst_q - 2'h1;
            strobe_q <= (burst_q != 2'h1) ? !strobe_q : 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            READ_OUT <= '0;
            INIT_BUSY_OUT <= 1'b1;
            CAL_BUSY_OUT <= 1'b0;
            BURST_LENGTH_CFG_OUT <= 8'h00;
        end
        else
        begin
            READ_OUT.data <= read_data_q;
            READ_OUT.strobe <= strobe_q;
            // High impedance from the cycle after clock enable is seen low
            READ_OUT.data_oe <= cke_q && (burst_q != 2'h0);
            READ_OUT.strobe_oe <= cke_q && (burst_q != 2'h0);
            INIT_BUSY_OUT <= init_busy_q;
            CAL_BUSY_OUT <= cal_busy_q;
            BURST_LENGTH_CFG_OUT <= wo_q[0];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_hiz_when_cke_low;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        !cke_q |=> !READ_OUT.data_oe && !READ_OUT.strobe_oe;
    endproperty
    a_hiz_when_cke_low: assert property (p_hiz_when_cke_low) else $error("outputs driven with cke low");

    property p_ro_write_ignored;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        CMD_IN.write_valid && classify(CMD_IN.address) != ACCESS_WRITE_ONLY |=> $stable(wo_q[0]);
    endproperty
    a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("non-writable write changed state");

    property p_read_strobes;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        cmd_read ##1 cke_q |=> READ_OUT.strobe_oe;
    endproperty
    a_read_strobes: assert property (p_read_strobes) else $error("read burst without strobe");

    property p_pattern_a;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        cmd_read && CMD_IN.address == ADDR_DQ_PATTERN_A |=> read_data_q == DQ_PATTERN_A_VALUE;
    endproperty
    a_pattern_a: assert property (p_pattern_a) else $error("pattern a wrong");

    property p_info_reserved_zero;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        cmd_read && CMD_IN.address == ADDR_DEVICE_INFO |=> read_data_q[7:5] == 3'h0;
    endproperty
    a_info_reserved_zero: assert property (p_info_reserved_zero) else $error("reserved bits not zero");

    property p_reset_restarts_init;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        reset_cmd |=> init_busy_q ##1 INIT_BUSY_OUT;
    endproperty
    a_reset_restarts_init: assert property (p_reset_restarts_init) else $error("reset did not restart init");

    property p_write_stores;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        cmd_write && CMD_IN.address == ADDR_DEVICE_FEATURE_ONE |=> wo_q[0] == $past(CMD_IN.operand);
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("write not stored");

    // Ten busy cycles exactly, split so that each repetition stays short
    property p_cal_length;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        $rose(cal_busy_q) |-> cal_busy_q [*5] ##1 cal_busy_q [*5] ##1 !cal_busy_q;
    endproperty
    a_cal_length: assert property (p_cal_length) else $error("calibration length wrong");

    property p_read_strobe_first;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        cmd_read ##1 cke_q |=> READ_OUT.strobe;
    endproperty
    a_read_strobe_first: assert property (p_read_strobe_first) else $error("burst did not open with strobe high");

    property p_info_tracks_init;
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        cmd_read && CMD_IN.address == ADDR_DEVICE_INFO
            |=> read_data_q[AUTO_INIT_STATUS_BIT_POS] == $past(init_busy_q);
    endproperty
    a_info_tracks_init: assert property (p_info_tracks_init) else $error("init status bit wrong");

endmodule

// File: inc/mode_reg_pkg.sv
package mode_reg_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DEVICE_INFO = 8'h00;
    localparam logic [7:0] ADDR_DEVICE_FEATURE_ONE = 8'h01;
    localparam logic [7:0] ADDR_DEVICE_FEATURE_TWO = 8'h02;
    localparam logic [7:0] ADDR_IO_CONFIG_ONE = 8'h03;
    localparam logic [7:0] ADDR_REFRESH_RATE_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MAKER_CODE = 8'h05;
    localparam logic [7:0] ADDR_REVISION_CODE_ONE = 8'h06;
    localparam logic [7:0] ADDR_REVISION_CODE_TWO = 8'h07;
    localparam logic [7:0] ADDR_WIDTH_DENSITY_TYPE = 8'h08;
    localparam logic [7:0] ADDR_VENDOR_TEST_MODE = 8'h09;
    localparam logic [7:0] ADDR_IMPEDANCE_CALIBRATION = 8'h0A;
    localparam logic [7:0] ADDR_PARTIAL_REFRESH_BANK_MASK = 8'h10;
    localparam logic [7:0] ADDR_PARTIAL_REFRESH_SEGMENT_MASK = 8'h11;
    localparam logic [7:0] ADDR_DQ_PATTERN_A = 8'h20;
    localparam logic [7:0] ADDR_DQ_PATTERN_B = 8'h28;
    localparam logic [7:0] ADDR_DEVICE_RESET_TRIGGER = 8'h3F;

    // ------------------------------------------------------------
    // Field layouts and fixed values
    // ------------------------------------------------------------
    localparam int AUTO_INIT_STATUS_BIT_POS = 0;
    localparam logic [7:0] DEVICE_INFO_USED_MASK = 8'h1F;
    localparam logic [7:0] DEVICE_FEATURE_TWO_USED_MASK = 8'h0F;
    localparam logic [7:0] IO_CONFIG_ONE_USED_MASK = 8'h0F;
    localparam logic [7:0] REFRESH_RATE_USED_MASK = 8'h87;
    localparam logic [7:0] WRITE_ONLY_RESET_VALUE = 8'h00;
    localparam logic [7:0] DQ_PATTERN_A_VALUE = 8'h55;
    localparam logic [7:0] DQ_PATTERN_B_VALUE = 8'hAA;
    localparam logic [7:0] READ_FILL_VALUE = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int AUTO_INIT_TIME_NS = 10000;
    localparam int AUTO_INIT_CYCLES = AUTO_INIT_TIME_NS / CLOCK_PERIOD_NS;
    localparam int CALIBRATION_TIME_NS = 1000;
    localparam int CALIBRATION_CYCLES = (CALIBRATION_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int READ_BURST_CYCLES = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ACCESS_RESERVED,
        ACCESS_READ_ONLY,
        ACCESS_WRITE_ONLY
    } access_class_type;

    typedef struct packed
    {
        logic read_valid;
        logic write_valid;
        logic [7:0] address;
        logic [7:0] operand;
    } mode_cmd_type;

    typedef struct packed
    {
        logic [7:0] data;
        logic data_oe;
        logic strobe;
        logic strobe_oe;
    } read_out_type;

endpackage

// File: tb/mem_ctrl_model.sv
module mem_ctrl_model
    import mode_reg_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Command side
    output logic cke_out,
    output mode_cmd_type cmd_out,
    // Read path
    input wire read_out_type read_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Power-up state
    // ------------------------------------------------------------
    initial
    begin
        cke_out = 1'b0;
        cmd_out = '0;
    end

    // ------------------------------------------------------------
    // Command tasks
    // ------------------------------------------------------------
    // Power-off is entered by holding clock enable low until the end
    task automatic set_cke(input logic level);
        @(posedge clk_in);
        #1 cke_out = level;
    endtask

    // Callers mask reserved bits to zero on writable registers only, and never aim at reserved places
    task automatic mrw(input logic [7:0] addr, input logic [7:0] op);
        @(posedge clk_in);
        #1;
        cmd_out.write_valid = 1'b1;
        cmd_out.address = addr;
        cmd_out.operand = op;
        @(posedge clk_in);
        #1;
        cmd_out.write_valid = 1'b0;
        // Released bus shows inverted lines so a stale value cannot pass
        cmd_out.address = ~addr;
        cmd_out.operand = ~op;
    endtask

    // Seen holds oe and strobe of both burst cycles, then oe after the burst
    task automatic mrr(input logic [7:0] addr, output logic [7:0] data, output logic [4:0] seen);
        @(posedge clk_in);
        #1;
        cmd_out.read_valid = 1'b1;
        cmd_out.address = addr;
        @(posedge clk_in);
        #1;
        cmd_out.read_valid = 1'b0;
        cmd_out.address = ~addr;
        @(posedge clk_in);
        #1;
        data = read_in.data;
        seen[4] = read_in.data_oe & read_in.strobe_oe;
        seen[3] = read_in.strobe;
        @(posedge clk_in);
        #1;
        seen[2] = read_in.data_oe & read_in.strobe_oe;
        seen[1] = read_in.strobe;
        @(posedge clk_in);
        #1;
        seen[0] = read_in.data_oe | read_in.strobe_oe;
    endtask
endmodule

// File: tb/sdram_mode_register_bank_tb.sv
`define CHK(name, expv, gotv) \
    begin \
        cmp_count++; \
        if ((gotv) !== (expv)) \
        begin \
            n_errors++; \
            $display("CHECK FAILED %s expected %0h seen %0h", name, expv, gotv); \
        end \
    end

module sdram_mode_register_bank_tb
    import mode_reg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    // Short init keeps the run brief; reads during init still fit inside it
    localparam int INIT_P = 20;
    localparam logic [7:0] MAKER_P = 8'h3C; // Arbitrary value
    localparam logic [7:0] REV1_P = 8'h21;  // Arbitrary value
    localparam logic [7:0] REV2_P = 8'h12;  // Arbitrary value
    localparam logic [7:0] WD_P = 8'h4B;
    localparam logic [7:0] RR_P = 8'hFF;
    localparam logic [7:0] RO_ADDR [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28};
    localparam logic [7:0] RO_EXP [7] = '{RR_P & REFRESH_RATE_USED_MASK, MAKER_P, REV1_P, REV2_P, WD_P,
                                         DQ_PATTERN_A_VALUE, DQ_PATTERN_B_VALUE};
    localparam logic [7:0] NR_ADDR [19] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0A, 8'h10, 8'h11, 8'h3F, 8'h0B,
                                           8'h0F, 8'h12, 8'h14, 8'h21, 8'h2F, 8'h30, 8'h40, 8'h7F, 8'h80, 8'hFF};

    logic clk;
    logic rst_n;
    logic cke;
    mode_cmd_type cmd;
    read_out_type rd;
    logic init_busy;
    logic cal_busy;
    logic [7:0] cfg;
    int n_errors = 0;
    int cmp_count = 0;

    sdram_mode_register_bank #(.AUTO_INIT_CYCLES_P(INIT_P), .MAKER_CODE_P(MAKER_P), .REVISION_ONE_P(REV1_P),
        .REVISION_TWO_P(REV2_P), .WIDTH_DENSITY_P(WD_P), .REFRESH_RATE_P(RR_P)) u_sdram_mode_register_bank (
        .CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .CKE_IN(cke), .CMD_IN(cmd), .READ_OUT(rd),
        .INIT_BUSY_OUT(init_busy), .CAL_BUSY_OUT(cal_busy), .BURST_LENGTH_CFG_OUT(cfg));

    mem_ctrl_model u_mem_ctrl_model (.clk_in(clk), .cke_out(cke), .cmd_out(cmd), .read_in(rd));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic test_done();
        if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic read_chk(input logic [7:0] addr, input logic [7:0] expv, input logic [7:0] mask);
        logic [7:0] data;
        logic [4:0] seen;
        u_mem_ctrl_model.mrr(addr, data, seen);
        `CHK("read data", expv & mask, data & mask)
        `CHK("read burst", 5'b11100, seen)
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic count_cal(input int span, output int n);
        n = 0;
        repeat (span)
        begin
            cycles(1);
            if (cal_busy === 1'b1)
                n++;
        end
    endtask

    task automatic wait_init();
        int k;
        for (k = 0; k < 200 && init_busy !== 1'b0; k++)
            cycles(1);
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, tests
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        #300000;
        n_errors++;
        test_done();
    end

    initial
    begin
        logic [7:0] data;
        logic [4:0] seen;
        int n;
        rst_n = 1'b0;
        cycles(7);
        `CHK("init in reset", 1'b1, init_busy)
        `CHK("out in reset", 11'h000, rd)
        cycles(1);
        rst_n = 1'b1;
        u_mem_ctrl_model.set_cke(1'b1);
        cycles(5);
        read_chk(ADDR_DEVICE_INFO, 8'h01, 8'hE1);
        wait_init();
        `CHK("init done", 1'b0, init_busy)
        read_chk(ADDR_DEVICE_INFO, 8'h00, ~DEVICE_INFO_USED_MASK | 8'h01);
        u_mem_ctrl_model.mrw(ADDR_DEVICE_FEATURE_ONE, 8'h52);
        cycles(2);
        `CHK("cfg write", 8'h52, cfg)
        for (int i = 0; i < 7; i++)
        begin
            u_mem_ctrl_model.mrw(RO_ADDR[i], ~RO_EXP[i]);
            read_chk(RO_ADDR[i], RO_EXP[i], 8'hFF);
        end
        u_mem_ctrl_model.mrw(ADDR_DEVICE_INFO, 8'hFF);
        cycles(3);
        `CHK("init after ro write", 1'b0, init_busy)
        for (int i = 0; i < 19; i++)
            read_chk(NR_ADDR[i], READ_FILL_VALUE, 8'hFF);
        u_mem_ctrl_model.mrw(ADDR_DEVICE_FEATURE_TWO, 8'hFF & DEVICE_FEATURE_TWO_USED_MASK);
        u_mem_ctrl_model.mrw(ADDR_IO_CONFIG_ONE, 8'hFF & IO_CONFIG_ONE_USED_MASK);
        u_mem_ctrl_model.mrw(ADDR_PARTIAL_REFRESH_BANK_MASK, 8'hA5);
        u_mem_ctrl_model.mrw(ADDR_PARTIAL_REFRESH_SEGMENT_MASK, 8'h5A);
        cycles(2);
        `CHK("cfg held", 8'h52, cfg)
        u_mem_ctrl_model.mrw(ADDR_IMPEDANCE_CALIBRATION, 8'hFF);
        count_cal(20, n);
        `CHK("cal length", CALIBRATION_CYCLES, n)
        u_mem_ctrl_model.mrw(ADDR_DEVICE_RESET_TRIGGER, 8'h00);
        cycles(3);
        `CHK("reset init", 1'b1, init_busy)
        `CHK("reset cfg", WRITE_ONLY_RESET_VALUE, cfg)
        // Calibration must not start while the device is still initialising
        u_mem_ctrl_model.mrw(ADDR_IMPEDANCE_CALIBRATION, 8'hFF);
        count_cal(12, n);
        `CHK("cal in init", 0, n)
        wait_init();
        u_mem_ctrl_model.mrw(ADDR_DEVICE_FEATURE_ONE, 8'h2A);
        cycles(2);
        `CHK("cfg rewrite", 8'h2A, cfg)
        // Power-off: clock enable low, no command may drive the outputs
        u_mem_ctrl_model.set_cke(1'b0);
        cycles(8);
        u_mem_ctrl_model.mrr(ADDR_DQ_PATTERN_A, data, seen);
        `CHK("hi-z oe", 3'b000, {seen[4], seen[2], seen[0]})
        u_mem_ctrl_model.mrw(ADDR_DEVICE_FEATURE_ONE, 8'h13);
        cycles(3);
        `CHK("cfg cke low", 8'h2A, cfg)
        `CHK("data oe", 1'b0, rd.data_oe)
        test_done();
    end
endmodule
